// *** brm_defs.vh ***
// Constants for the bit rectangle block mover.
// Assumes inclusion by brm_block_mover.v and brm_word_combine.v.
`ifndef BRM_DEFS_VH
`define BRM_DEFS_VH

// Wishbone register byte offsets
`define BRM_REG_CTRL 8'h00
`define BRM_REG_ACC1 8'h04
`define BRM_REG_ACC2 8'h08
`define BRM_REG_STAT 8'h0C

// Control register fields
`define BRM_CTRL_START 0

// Status register fields
`define BRM_ST_BUSY 0
`define BRM_ST_DONE 1
`define BRM_ST_TRAP 2
`define BRM_ST_INTR 3

// Parameter table layout, word indices
`define BRM_TBL_WORDS 16
`define BRM_TBL_CTRL 4'h0
`define BRM_TBL_DBASE 4'h2
`define BRM_TBL_DPITCH 4'h3
`define BRM_TBL_DLX 4'h4
`define BRM_TBL_DTY 4'h5
`define BRM_TBL_DW 4'h6
`define BRM_TBL_DH 4'h7
`define BRM_TBL_SBASE 4'h8
`define BRM_TBL_SPITCH 4'h9
`define BRM_TBL_SLX 4'hA
`define BRM_TBL_STY 4'hB
`define BRM_TBL_PAT0 4'hC
`define BRM_TBL_LAST 4'hF

// Control word fields; control bit n (MSB numbered 0) is bit 15-n
`define BRM_FN_SRC_ALT 5
`define BRM_FN_DST_ALT 4
`define BRM_FN_SRCSEL_HI 3
`define BRM_FN_SRCSEL_LO 2
`define BRM_FN_OP_HI 1
`define BRM_FN_OP_LO 0

// Source select values
`define BRM_SRC_RECT 2'h0
`define BRM_SRC_INV 2'h1
`define BRM_SRC_AND_PAT 2'h2
`define BRM_SRC_PAT 2'h3

// Operation values
`define BRM_OP_REPLACE 2'h0
`define BRM_OP_PAINT 2'h1
`define BRM_OP_INVERT 2'h2
`define BRM_OP_ERASE 2'h3

`endif

// *** brm_word_combine.v ***
// One destination word: aligns source bits, picks the source value,
// applies the operation and keeps bits outside the mask.
// Assumes pixel 0 of a word is its most significant bit.
`timescale 1ns/1ps
`default_nettype none
`include "brm_defs.vh"

module brm_word_combine (
    // Source pair and alignment
    input wire [15:0] src_first,
    input wire [15:0] src_second,
    input wire [3:0] skew,
    // Pattern and destination
    input wire [15:0] pattern,
    input wire [15:0] dest_old,
    input wire [15:0] mask,
    // Mode
    input wire [1:0] src_select,
    input wire [1:0] op,
    // Result
    output reg [15:0] dest_new
);
    wire [31:0] pair = {src_first, src_second} << skew;
    wire [15:0] aligned = pair[31:16];
    reg [15:0] srcv;
    reg [15:0] opv;

    always @* begin
        case (src_select)
            `BRM_SRC_RECT: srcv = aligned;
            `BRM_SRC_INV: srcv = ~aligned;
            `BRM_SRC_AND_PAT: srcv = aligned & pattern;
            default: srcv = pattern;
        endcase
        case (op)
            `BRM_OP_REPLACE: opv = srcv;
            `BRM_OP_PAINT: opv = srcv | dest_old;
            `BRM_OP_INVERT: opv = srcv ^ dest_old;
            default: opv = ~srcv & dest_old;
        endcase
        dest_new = (opv & mask) | (dest_old & ~mask);
    end
endmodule // brm_word_combine

`default_nettype wire

// *** brm_block_mover.v ***
// Bit rectangle block mover: Wishbone register slave plus a word
// addressed memory master that runs the rectangle transfer.
// Assumes memory holds req until a one-cycle ack on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "brm_defs.vh"

// Summary of operation
// - Only accumulator two keeps its entry value
// - Missing control store raises unimplemented trap
// - Sixteen word parameter table read first
// - Negative width or height does nothing
// - Interrupt only at line start, save progress
// - Line word address is base plus y*pitch
// - Rectangle: base, pitch, left, top, width, height
// - Control bits 10, 11 pick alternate banks
// - Operation: replace, paint, invert, erase
// - Source: rect, complement, rect and pattern, pattern
// - One pattern word per visited line, cycled
// - Line order follows destination versus source top
// - Source size equals destination size
// - Overlap handled by transfer order; same bitmap
// - Per word cost roughly fixed by accesses
// - Per line cost small and fixed
// - Setup cost dominated by table fetch
module brm_block_mover (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Main memory master
    output reg mem_req,
    output reg mem_we,
    output reg mem_alt_bank,
    output reg [15:0] mem_addr,
    output reg [15:0] mem_wdata,
    input wire [15:0] mem_rdata,
    input wire mem_ack,
    // Processor side
    input wire ctrl_store_present,
    input wire irq_pending,
    output reg unimpl_trap,
    output reg pc_backup,
    output reg move_done
);
    localparam [8:0] S_IDLE = 9'h001;
    localparam [8:0] S_FETCH = 9'h002;
    localparam [8:0] S_CHECK = 9'h004;
    localparam [8:0] S_LINE = 9'h008;
    localparam [8:0] S_SRC0 = 9'h010;
    localparam [8:0] S_SRC1 = 9'h020;
    localparam [8:0] S_DRD = 9'h040;
    localparam [8:0] S_DWR = 9'h080;
    localparam [8:0] S_FIN = 9'h100;

    ////////////////////////////////////////////////////////////////////
    // Pin synchroniser for the control store presence strap
    reg cs_meta_q;
    reg cs_sync_q;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_meta_q <= 1'b0;
            cs_sync_q <= 1'b0;
        end else begin
            cs_meta_q <= ctrl_store_present;
            cs_sync_q <= cs_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State
    reg [8:0] st_q;
    reg [3:0] idx_q;
    reg [15:0] tbl_q [0:`BRM_TBL_WORDS-1];
    reg [15:0] line_q;
    reg first_q;
    reg [15:0] wd_q;
    reg [15:0] s0_q;
    reg [15:0] s1_q;
    reg [15:0] dold_q;
    reg [15:0] acc1_q;
    reg [15:0] acc2_q;
    reg done_q;
    reg trap_q;
    reg intr_q;
    wire busy = ~st_q[0];
    wire ack_ok = mem_ack & mem_req;

    ////////////////////////////////////////////////////////////////////
    // Table fields and geometry
    wire [15:0] fn = tbl_q[`BRM_TBL_CTRL];
    wire [15:0] dbase = tbl_q[`BRM_TBL_DBASE];
    wire [15:0] dpitch = tbl_q[`BRM_TBL_DPITCH];
    wire [15:0] dest_left_bit = tbl_q[`BRM_TBL_DLX];
    wire [15:0] dest_top_line = tbl_q[`BRM_TBL_DTY];
    wire [15:0] dwid = tbl_q[`BRM_TBL_DW];
    wire [15:0] dht = tbl_q[`BRM_TBL_DH];
    wire [15:0] sbase = tbl_q[`BRM_TBL_SBASE];
    wire [15:0] spitch = tbl_q[`BRM_TBL_SPITCH];
    wire [15:0] src_left_bit = tbl_q[`BRM_TBL_SLX];
    wire [15:0] src_top_line = tbl_q[`BRM_TBL_STY];
    // Control bits 0 to 9 are not decoded
    wire src_alt = fn[`BRM_FN_SRC_ALT];
    wire dst_alt = fn[`BRM_FN_DST_ALT];
    wire [1:0] src_sel = fn[`BRM_FN_SRCSEL_HI:`BRM_FN_SRCSEL_LO];
    wire [1:0] op = fn[`BRM_FN_OP_HI:`BRM_FN_OP_LO];
    wire need_src = (src_sel != `BRM_SRC_PAT);

    // Equal tops go top down; only the horizontal order matters then
    wire top_down = ~($signed(dest_top_line) > $signed(src_top_line));
    wire right_first = (dest_top_line == src_top_line) &&
        ($signed(dest_left_bit) > $signed(src_left_bit));
    wire [15:0] yoff = top_down ? line_q :
        dht - 16'h0001 - line_q;
    wire [15:0] dlast_px = dest_left_bit + dwid - 16'h0001;
    wire [15:0] fw = {4'h0, dest_left_bit[15:4]};
    wire [15:0] lw = {4'h0, dlast_px[15:4]};
    wire [15:0] w_start = right_first ? lw : fw;
    wire [15:0] w_end = right_first ? fw : lw;

    // Source pixel under the first pixel of this destination word
    wire [15:0] sx0 = src_left_bit + {wd_q[11:0], 4'h0} - dest_left_bit;
    wire [15:0] srcw = {{4{sx0[15]}}, sx0[15:4]};
    wire [3:0] lo = (wd_q == fw) ? dest_left_bit[3:0] : 4'h0;
    wire [3:0] hi = (wd_q == lw) ? dlast_px[3:0] : 4'hF;
    wire [15:0] mask = (16'hFFFF >> lo) &
        (16'hFFFF << (4'hF - hi));

    wire [31:0] dprod = (dest_top_line + yoff) * dpitch;
    wire [31:0] sprod = (src_top_line + yoff) * spitch;
    wire [15:0] dline = dbase + dprod[15:0];
    wire [15:0] sline = sbase + sprod[15:0];
    wire [15:0] daddr = dline + wd_q;
    wire [15:0] saddr = sline + srcw;
    wire [3:0] pat_idx = `BRM_TBL_PAT0 + {2'h0, line_q[1:0]};
    wire [15:0] pattern = tbl_q[pat_idx];
    wire [15:0] dnew;

    brm_word_combine u_comb (
        .src_first(s0_q),
        .src_second(s1_q),
        .skew(sx0[3:0]),
        .pattern(pattern),
        .dest_old(dold_q),
        .mask(mask),
        .src_select(src_sel),
        .op(op),
        .dest_new(dnew)
    );

    ////////////////////////////////////////////////////////////////////
    // Register writes
    wire wb_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Writes land on the edge that samples ack, as the master expects
    wire wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    wire start = wr && (wb_adr_i == `BRM_REG_CTRL) && wb_sel_i[0] &&
        wb_dat_i[`BRM_CTRL_START] && !busy;

    ////////////////////////////////////////////////////////////////////
    // Transfer sequencer
    integer i;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= S_IDLE;
            idx_q <= 4'h0;
            line_q <= 16'h0000;
            first_q <= 1'b0;
            wd_q <= 16'h0000;
            s0_q <= 16'h0000;
            s1_q <= 16'h0000;
            dold_q <= 16'h0000;
            acc1_q <= 16'h0000;
            acc2_q <= 16'h0000;
            done_q <= 1'b0;
            trap_q <= 1'b0;
            intr_q <= 1'b0;
            unimpl_trap <= 1'b0;
            pc_backup <= 1'b0;
            move_done <= 1'b0;
            for (i = 0; i < `BRM_TBL_WORDS; i = i + 1)
                tbl_q[i] <= 16'h0000;
        end else begin
            unimpl_trap <= 1'b0;
            pc_backup <= 1'b0;
            move_done <= 1'b0;
            if (wr && !busy && (wb_adr_i == `BRM_REG_ACC1)) begin
                if (wb_sel_i[0])
                    acc1_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    acc1_q[15:8] <= wb_dat_i[15:8];
            end
            if (wr && !busy && (wb_adr_i == `BRM_REG_ACC2)) begin
                if (wb_sel_i[0])
                    acc2_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    acc2_q[15:8] <= wb_dat_i[15:8];
            end
            case (st_q)
                S_IDLE: begin
                    if (start) begin
                        done_q <= 1'b0;
                        trap_q <= 1'b0;
                        intr_q <= 1'b0;
                        idx_q <= 4'h0;
                        if (!cs_sync_q) begin
                            trap_q <= 1'b1;
                            unimpl_trap <= 1'b1;
                        end else begin
                            st_q <= S_FETCH;
                        end
                    end
                end
                S_FETCH: begin
                    if (ack_ok) begin
                        tbl_q[idx_q] <= mem_rdata;
                        idx_q <= idx_q + 4'h1;
                        if (idx_q == `BRM_TBL_LAST)
                            st_q <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (dwid[15] || dht[15] || dwid == 16'h0000 ||
                        dht == 16'h0000) begin
                        st_q <= S_FIN;
                    end else begin
                        // Relies on a zeroed accumulator one for new runs
                        line_q <= (acc1_q == 16'h0000) ? 16'h0000 :
                            acc1_q - 16'h0001;
                        first_q <= 1'b1;
                        st_q <= S_LINE;
                    end
                end
                S_LINE: begin
                    if (line_q >= dht) begin
                        st_q <= S_FIN;
                    end else if (irq_pending && !first_q) begin
                        // First line always runs, so progress is assured
                        acc1_q <= line_q + 16'h0001;
                        intr_q <= 1'b1;
                        pc_backup <= 1'b1;
                        st_q <= S_IDLE;
                    end else begin
                        first_q <= 1'b0;
                        wd_q <= w_start;
                        st_q <= need_src ? S_SRC0 : S_DRD;
                    end
                end
                S_SRC0: begin
                    if (ack_ok) begin
                        s0_q <= mem_rdata;
                        st_q <= S_SRC1;
                    end
                end
                S_SRC1: begin
                    if (ack_ok) begin
                        s1_q <= mem_rdata;
                        st_q <= S_DRD;
                    end
                end
                S_DRD: begin
                    if (ack_ok) begin
                        dold_q <= mem_rdata;
                        st_q <= S_DWR;
                    end
                end
                S_DWR: begin
                    if (ack_ok) begin
                        if (wd_q == w_end) begin
                            line_q <= line_q + 16'h0001;
                            st_q <= S_LINE;
                        end else begin
                            wd_q <= right_first ? wd_q - 16'h0001 :
                                wd_q + 16'h0001;
                            st_q <= need_src ? S_SRC0 : S_DRD;
                        end
                    end
                end
                default: begin
                    acc1_q <= 16'h0000;
                    done_q <= 1'b1;
                    move_done <= 1'b1;
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Memory master: one access per state, sixteen in S_FETCH, request raised the cycle
    // after entry; at least three cycles per access sets the real cost
    wire mem_state = st_q[1] | st_q[4] | st_q[5] | st_q[6] | st_q[7];
    reg [15:0] addr_d;
    always @* begin
        addr_d = acc2_q + {12'h000, idx_q};
        if (st_q[4])
            addr_d = saddr;
        else if (st_q[5])
            addr_d = saddr + 16'h0001;
        else if (st_q[6] | st_q[7])
            addr_d = daddr;
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_alt_bank <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wdata <= 16'h0000;
        end else begin
            mem_req <= mem_state & ~ack_ok;
            mem_we <= st_q[7];
            mem_alt_bank <= ((st_q[4] | st_q[5]) & src_alt) |
                ((st_q[6] | st_q[7]) & dst_alt);
            mem_addr <= addr_d;
            mem_wdata <= dnew;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the strobe, reads of
    // unmapped offsets return zero
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_go;
            wb_dat_o <= 32'h00000000;
            if (wb_adr_i == `BRM_REG_CTRL)
                wb_dat_o <= {31'h00000000, busy};
            else if (wb_adr_i == `BRM_REG_ACC1)
                wb_dat_o <= {16'h0000, acc1_q};
            else if (wb_adr_i == `BRM_REG_ACC2)
                wb_dat_o <= {16'h0000, acc2_q};
            else if (wb_adr_i == `BRM_REG_STAT)
                wb_dat_o <= {28'h0000000, intr_q, trap_q, done_q, busy};
        end
    end
endmodule // brm_block_mover

`default_nettype wire

// *** brm_block_mover_properties.sv ***
// Port checker for the bit rectangle block mover.
// Assumes one clock and the asynchronous active high reset of the top.
`timescale 1ns/1ps
`default_nettype none
module brm_block_mover_props (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Memory
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_alt_bank,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic mem_ack,
    // Processor side
    input wire logic ctrl_store_present,
    input wire logic irq_pending,
    input wire logic unimpl_trap,
    input wire logic pc_backup,
    input wire logic move_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_mem_wait;
        mem_req && !mem_ack;
    endsequence
    sequence s_mem_end;
        mem_req && mem_ack ##1 !mem_req;
    endsequence

    property p_wb_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    property p_wb_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_unmapped;
        wb_ack_o && !wb_we_i && wb_adr_i >= 8'h10 |-> wb_dat_o == 32'h0;
    endproperty
    property p_mem_hold;
        s_mem_wait |=> mem_req && $stable(mem_addr) && $stable(mem_we)
            && $stable(mem_wdata) && $stable(mem_alt_bank);
    endproperty
    property p_mem_release;
        mem_req && mem_ack |-> s_mem_end;
    endproperty
    property p_trap_quiet;
        unimpl_trap |-> !mem_req [*3];
    endproperty
    property p_trap_cause;
        unimpl_trap |-> !$past(ctrl_store_present, 3);
    endproperty
    property p_irq_cause;
        pc_backup |-> $past(irq_pending);
    endproperty
    property p_done_idle;
        move_done |-> !mem_req;
    endproperty
    property p_evt_pulse;
        (unimpl_trap || pc_backup || move_done)
            |=> !(unimpl_trap || pc_backup || move_done);
    endproperty

    a_wb_answer: assert property (p_wb_answer)
        else $error("wishbone request not answered next cycle");
    a_wb_pulse: assert property (p_wb_pulse)
        else $error("wishbone ack longer than one cycle");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero");
    a_mem_hold: assert property (p_mem_hold)
        else $error("memory request changed before ack");
    a_mem_release: assert property (p_mem_release)
        else $error("memory request not dropped after ack");
    a_trap_quiet: assert property (p_trap_quiet)
        else $error("memory access around a refused start");
    a_trap_cause: assert property (p_trap_cause)
        else $error("trap with control store fitted");
    a_irq_cause: assert property (p_irq_cause)
        else $error("stop without pending interrupt");
    a_done_idle: assert property (p_done_idle)
        else $error("memory busy at completion");
    a_evt_pulse: assert property (p_evt_pulse)
        else $error("completion event longer than one cycle");
endmodule // brm_block_mover_props

bind brm_block_mover brm_block_mover_props u_props (.clk, .sys_rst,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .mem_req, .mem_we, .mem_alt_bank, .mem_addr, .mem_wdata, .mem_ack,
    .ctrl_store_present, .irq_pending, .unimpl_trap, .pc_backup,
    .move_done);
`default_nettype wire

// *** brm_mem_model.sv ***
// Word addressed main memory with an alternate bank.
// Assumes the engine holds mem_req until a one-cycle mem_ack.
`timescale 1ns/1ps
`default_nettype none
module brm_mem_model (
    // Clock
    input wire logic clk,
    // Memory port
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_alt_bank,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack,
    // Latency control
    input wire logic slow
);
    logic [15:0] mem_q [0:1][0:4095];
    logic [1:0] wait_q;

    initial begin
        wait_q = 2'h0;
        mem_ack = 1'b0;
        mem_rdata = 16'h5A5A;
        for (int i = 0; i < 8192; i++) begin
            mem_q[i / 4096][i % 4096] = 16'(i * 7);
        end
    end

    always @(posedge clk) begin
        mem_ack <= 1'b0;
        // Read data churns outside ack so stale values are never trusted
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (wait_q == (slow ? 2'h3 : 2'h0)) begin
                wait_q <= 2'h0;
                mem_ack <= 1'b1;
                if (mem_we) begin
                    mem_q[mem_alt_bank][mem_addr[11:0]] <= mem_wdata;
                end else begin
                    mem_rdata <= mem_q[mem_alt_bank][mem_addr[11:0]];
                end
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule // brm_mem_model
`default_nettype wire

// *** brm_block_mover_tb_top.sv ***
// Self-checking bench: Wishbone driver, memory model, result queues.
// Assumes the engine and its checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "brm_defs.vh"
module brm_block_mover_tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, mem_req, mem_we, mem_alt_bank, mem_ack;
    logic [15:0] mem_addr, mem_wdata, mem_rdata;
    logic ctrl_store_present = 1'b0, irq_pending = 1'b0, slow = 1'b0;
    logic unimpl_trap, pc_backup, move_done;
    logic [31:0] rng = 32'h20;
    logic [31:0] rd_q [$];
    logic [32:0] wr_q [$];
    int errors = 0, checks_done = 0;

    brm_block_mover u_brm_block_mover (.clk, .sys_rst, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .mem_req, .mem_we, .mem_alt_bank, .mem_addr,
        .mem_wdata, .mem_rdata, .mem_ack, .ctrl_store_present,
        .irq_pending, .unimpl_trap, .pc_backup, .move_done);
    brm_mem_model u_brm_mem_model (.clk, .mem_req, .mem_we, .mem_alt_bank,
        .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .slow);

    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic [15:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[15:0];
    endfunction

    function automatic logic [15:0] comb(input logic [1:0] sel, op,
                                         input logic [15:0] s, d, p);
        logic [15:0] v;
        v = sel == 2'h0 ? s : sel == 2'h1 ? ~s : sel == 2'h2 ? s & p : p;
        return op == 2'h0 ? v : op == 2'h1 ? v | d : op == 2'h2 ? v ^ d
            : ~v & d;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // One classic cycle; cyc stays low at least one clock between cycles
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] dat);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) begin
            check(1'b0, 1'b1);
            end_of_test();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        wb(1'b0, a, 32'h0);
    endtask

    task automatic tbl(input logic [15:0] fn, dest_left_bit, dest_top_line, dw, dh, src_top_line, pat);
        logic [15:0] w [16];
        w = '{fn, 16'h0, 16'h0200, 16'h0004, dest_left_bit, dest_top_line, dw, dh,
              16'h0300, 16'h0004, 16'h0000, src_top_line, pat, pat, pat, pat};
        for (int i = 0; i < 16; i++) begin
            u_brm_mem_model.mem_q[0][12'h100 + i] = w[i];
        end
    endtask

    task automatic go(input logic fresh, input logic [2:0] m);
        int n;
        if (fresh) wb(1'b1, `BRM_REG_ACC1, 32'h0);
        wb(1'b1, `BRM_REG_ACC2, 32'h0100);
        wb(1'b1, `BRM_REG_CTRL, 32'h1);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (({unimpl_trap, pc_backup, move_done} & m) === 3'h0
                   && n < 20000);
        check(n < 20000, 1'b1);
        if (n >= 20000) end_of_test();
    endtask

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        logic [32:0] exp;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            check({1'b0, wb_dat_o}, {1'b0, rd_q.pop_front()});
        end
        if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b1) begin
            exp = wr_q.size() > 0 ? wr_q.pop_front() : '1;
            check({mem_alt_bank, mem_addr, mem_wdata}, exp);
        end
    end

    initial begin
        logic [15:0] s, d, p;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`BRM_REG_STAT, 32'h0);
        rd(8'h10, 32'h0);
        tbl(16'h0, 16'h0, 16'h0, 16'h10, 16'h1, 16'h0, 16'h0);
        go(1'b1, 3'b100);
        rd(`BRM_REG_STAT, 32'h4);
        ctrl_store_present <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            s = xs();
            d = xs();
            p = xs();
            slow <= i[0];
            u_brm_mem_model.mem_q[0][12'h300] = s;
            u_brm_mem_model.mem_q[0][12'h200] = d;
            tbl({12'h0, i[1:0], i[3:2]}, 16'h0, 16'h0, 16'h10, 16'h1,
                16'h0, p);
            p = comb(i[1:0], i[3:2], s, d, p);
            wr_q.push_back({1'b0, 16'h0200, p});
            go(1'b1, 3'b001);
        end
        rd(`BRM_REG_ACC2, 32'h100);
        rd(`BRM_REG_STAT, 32'h2);
        s = xs();
        d = xs();
        u_brm_mem_model.mem_q[0][12'h300] = s;
        u_brm_mem_model.mem_q[0][12'h200] = d;
        tbl(16'h0, 16'h4, 16'h0, 16'h8, 16'h1, 16'h0, 16'h0);
        p = d & 16'hF00F | s >> 4 & 16'h0FF0;
        wr_q.push_back({1'b0, 16'h0200, p});
        go(1'b1, 3'b001);
        tbl(16'h0, 16'h0, 16'h0, 16'h10, 16'hFFFF, 16'h0, 16'h0);
        go(1'b1, 3'b001);
        tbl(16'h0, 16'h0, 16'h0, 16'hFFFF, 16'h1, 16'h0, 16'h0);
        go(1'b1, 3'b001);
        u_brm_mem_model.mem_q[1][12'h300] = s;
        u_brm_mem_model.mem_q[0][12'h300] = ~s;
        tbl(16'h0020, 16'h0, 16'h0, 16'h10, 16'h1, 16'h0, 16'h0);
        wr_q.push_back({1'b0, 16'h0200, s});
        go(1'b1, 3'b001);
        tbl(16'h0010, 16'h0, 16'h0, 16'h10, 16'h1, 16'h0, 16'h0);
        wr_q.push_back({1'b1, 16'h0200, ~s});
        go(1'b1, 3'b001);
        // Same bitmap, dest four pixels right: only right to left is safe
        tbl(16'h0, 16'h4, 16'h0, 16'h20, 16'h1, 16'h0, 16'h0);
        u_brm_mem_model.mem_q[0][12'h108] = 16'h0200;
        s = xs();
        d = xs();
        p = xs();
        u_brm_mem_model.mem_q[0][12'h200] = s;
        u_brm_mem_model.mem_q[0][12'h201] = d;
        u_brm_mem_model.mem_q[0][12'h202] = p;
        wr_q.push_back({1'b0, 16'h0202, d[3:0], p[11:0]});
        wr_q.push_back({1'b0, 16'h0201, s[3:0], d[15:4]});
        wr_q.push_back({1'b0, 16'h0200, s[15:12], s[15:4]});
        go(1'b1, 3'b001);
        // Pattern words handed over already phased for these lines
        tbl(16'h000C, 16'h0, 16'h0, 16'h10, 16'h4, 16'h0, 16'h0);
        for (int k = 0; k < 4; k++) begin
            p = xs();
            u_brm_mem_model.mem_q[0][12'h10C + k] = p;
            wr_q.push_back({1'b0, 16'h0200 + 16'(4 * k), p});
        end
        go(1'b1, 3'b001);
        for (int y = 2; y >= 0; y--) begin
            s = xs();
            u_brm_mem_model.mem_q[0][12'h300 + 4 * y] = s;
            wr_q.push_back({1'b0, 16'h0204 + 16'(4 * y), s});
        end
        irq_pending <= 1'b1;
        tbl(16'h0, 16'h0, 16'h1, 16'h10, 16'h3, 16'h0, 16'h0);
        go(1'b1, 3'b010);
        irq_pending <= 1'b0;
        rd(`BRM_REG_ACC1, 32'h2);
        rd(`BRM_REG_STAT, 32'h8);
        go(1'b0, 3'b001);
        rd(`BRM_REG_ACC1, 32'h0);
        repeat (4) @(posedge clk);
        check(33'(wr_q.size()), 33'h0);
        check(33'(rd_q.size()), 33'h0);
        end_of_test();
    end
endmodule // brm_block_mover_tb_top
`default_nettype wire
